// ===== include/pfcv_defines.svh
// Offsets, field positions, reset values and timing counts of the output-voltage limits block.
`ifndef PFCV_DEFINES_SVH
`define PFCV_DEFINES_SVH
`define PFCV_OFS_OV_WARN      8'h42
`define PFCV_OFS_UV_WARN      8'h43
`define PFCV_OFS_UV_FAULT     8'h44
`define PFCV_OFS_UV_RESP      8'h4F
`define PFCV_EXP_MSB          15
`define PFCV_EXP_LSB          11
`define PFCV_MANT_MSB         10
`define PFCV_RESP_CODE_MSB    7
`define PFCV_RESP_CODE_LSB    6
`define PFCV_RETRY_MSB        5
`define PFCV_RETRY_LSB        3
`define PFCV_DELAY_MSB        2
`define PFCV_DELAY_LSB        0
`define PFCV_RST_OV_MANT      11'h7FF
`define PFCV_RST_UV_MANT      11'h000
`define PFCV_RST_RESP         8'h00
`define PFCV_RETRY_INFINITE   3'h7
`define PFCV_CLOCK_HZ         20000000
`define PFCV_CYCLES_PER_MS    (`PFCV_CLOCK_HZ / 1000)
`define PFCV_DELAY1_BASE_MS   32'd10
`define PFCV_DELAY2_MS_0      32'd252
`define PFCV_DELAY2_MS_1      32'd558
`define PFCV_DELAY2_MS_2      32'd924
`define PFCV_DELAY2_MS_3      32'd1260
`define PFCV_DELAY2_MS_4      32'd1596
`define PFCV_DELAY2_MS_5      32'd1932
`define PFCV_DELAY2_MS_6      32'd2268
`define PFCV_DELAY2_MS_7      32'd2604
`endif

// ===== include/pfcv_pkg.sv
// Types and small helpers shared by the output-voltage limits block.
`include "pfcv_defines.svh"
package pfcv_pkg;
  // Reaction codes held in the top two bits of the reaction register.
  typedef enum logic [1:0] {
    PFCV_RESP_IGNORE    = 2'h0,
    PFCV_RESP_DELAYED   = 2'h1,
    PFCV_RESP_IMMEDIATE = 2'h2,
    PFCV_RESP_SPARE     = 2'h3
  } pfcv_resp_code_t;
  // Fault reaction sequencer states, Gray coded along the usual path.
  typedef enum logic [2:0] {
    PFCV_ST_IDLE    = 3'h0,
    PFCV_ST_DELAY   = 3'h1,
    PFCV_ST_OFF     = 3'h3,
    PFCV_ST_RESTART = 3'h2,
    PFCV_ST_LATCH   = 3'h6
  } pfcv_state_t;
  // Whole state of the reaction sequencer.
  typedef struct packed {
    pfcv_state_t state;
    logic [31:0] timer;
    logic [2:0]  retries;
    logic        out_en;
    logic        latched;
  } pfcv_resp_st_t;
  // Sign-extend the three-bit two's complement exponent to the five-bit field.
  function automatic logic [4:0] pfcv_exp5(input logic [2:0] e);
    return {{2{e[2]}}, e};
  endfunction
  // Restart interval in milliseconds for each delay selection.
  function automatic logic [31:0] pfcv_delay2_ms(input logic [2:0] sel);
    unique case (sel)
      3'h0: return `PFCV_DELAY2_MS_0;
      3'h1: return `PFCV_DELAY2_MS_1;
      3'h2: return `PFCV_DELAY2_MS_2;
      3'h3: return `PFCV_DELAY2_MS_3;
      3'h4: return `PFCV_DELAY2_MS_4;
      3'h5: return `PFCV_DELAY2_MS_5;
      3'h6: return `PFCV_DELAY2_MS_6;
      3'h7: return `PFCV_DELAY2_MS_7;
    endcase
  endfunction
endpackage : pfcv_pkg

// ===== include/pfcv_resp_if.sv
// Link between the register bank and the undervoltage fault reaction sequencer.
`timescale 1ns/1ps
`default_nettype none
interface pfcv_resp_if;
  logic       uv_fault;     // Undervoltage fault flag, registered.
  logic [1:0] code;         // Reaction code.
  logic [2:0] retry_limit;  // Restart attempts allowed.
  logic [2:0] delay_sel;    // Delay pair selection.
  logic       out_en;       // Output enable from the sequencer.
  logic       latched;      // Output locked off until reset.
  modport bank (output uv_fault, code, retry_limit, delay_sel, input out_en, latched);
  modport resp (input uv_fault, code, retry_limit, delay_sel, output out_en, latched);
endinterface : pfcv_resp_if
`default_nettype wire

// ===== logic/pfcv_resp.sv
// Undervoltage fault reaction sequencer: delay, shutdown, timed restarts and lock-off.
`timescale 1ns/1ps
`default_nettype none
`include "pfcv_defines.svh"
module pfcv_resp
  import pfcv_pkg::*;
#(
  parameter int unsigned P_CYCLES_PER_MS = `PFCV_CYCLES_PER_MS  // Clock cycles per millisecond.
) (
  input  wire logic   i_clock,    // Block clock.
  input  wire logic   i_rst_n,    // Synchronised active-low reset.
  pfcv_resp_if.resp   u_link      // Settings in, output enable out.
);
  pfcv_resp_st_t st_q;      // Registered state.
  pfcv_resp_st_t st_d;      // Next state.
  logic [31:0]   d1_cyc;    // First delay in cycles.
  logic [31:0]   d2_cyc;    // Restart interval in cycles.

  // Decide between another restart and lock-off once the output is shut down.
  function automatic pfcv_state_t pfcv_after_fault(input logic [2:0] used, input logic [2:0] lim);
    if (lim == `PFCV_RETRY_INFINITE || used < lim) begin
      return PFCV_ST_OFF;
    end
    return PFCV_ST_LATCH;
  endfunction

  // First delay doubles per step from its base; the restart interval is a table.
  assign d1_cyc = (`PFCV_DELAY1_BASE_MS << u_link.delay_sel) * P_CYCLES_PER_MS;
  assign d2_cyc = pfcv_delay2_ms(u_link.delay_sel) * P_CYCLES_PER_MS;

  // Next-state logic. A restart grants the output one first-delay window to recover.
  always_comb begin
    st_d = st_q;
    unique case (st_q.state)
      PFCV_ST_IDLE: begin
        st_d.out_en = 1'b1;
        st_d.timer  = 32'h0000_0000;
        if (!u_link.uv_fault) begin
          st_d.retries = 3'h0;
        end else if (u_link.code == PFCV_RESP_DELAYED) begin
          st_d.state = PFCV_ST_DELAY;
        end else if (u_link.code != PFCV_RESP_IGNORE) begin
          st_d.out_en = 1'b0;
          st_d.state  = pfcv_after_fault(st_q.retries, u_link.retry_limit);
        end
      end
      PFCV_ST_DELAY, PFCV_ST_RESTART: begin
        st_d.timer = st_q.timer + 32'h0000_0001;
        if (!u_link.uv_fault) begin
          st_d.state = PFCV_ST_IDLE;
        end else if (st_q.timer + 32'h0000_0001 >= d1_cyc) begin
          st_d.out_en = 1'b0;
          st_d.timer  = 32'h0000_0000;
          st_d.state  = pfcv_after_fault(st_q.retries, u_link.retry_limit);
        end
      end
      PFCV_ST_OFF: begin
        st_d.out_en = 1'b0;
        st_d.timer  = st_q.timer + 32'h0000_0001;
        if (st_q.timer + 32'h0000_0001 >= d2_cyc) begin
          st_d.timer  = 32'h0000_0000;
          st_d.out_en = 1'b1;
          st_d.state  = PFCV_ST_RESTART;
          if (u_link.retry_limit != `PFCV_RETRY_INFINITE) begin
            st_d.retries = st_q.retries + 3'h1;
          end
        end
      end
      PFCV_ST_LATCH: begin
        st_d.out_en  = 1'b0;
        st_d.latched = 1'b1;
      end
      default: begin
        st_d.out_en = 1'b0;
        st_d.state  = PFCV_ST_LATCH;
      end
    endcase
  end

  // State register; a cleared state has the output running.
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= '{state: PFCV_ST_IDLE, timer: 32'h0000_0000, retries: 3'h0,
                out_en: 1'b1, latched: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign u_link.out_en  = st_q.out_en;
  assign u_link.latched = st_q.latched;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  a_ignore_keeps_on: assert property (
    (st_q.state == PFCV_ST_IDLE && u_link.code == PFCV_RESP_IGNORE) |=> st_q.out_en)
    else $error("Output dropped while faults are ignored.");
  a_delay_keeps_on: assert property (
    (st_q.state == PFCV_ST_IDLE && u_link.uv_fault && u_link.code == PFCV_RESP_DELAYED)
    |=> (st_q.state == PFCV_ST_DELAY && st_q.out_en))
    else $error("Delayed reaction did not keep the output on.");
  a_delay_expiry: assert property (
    (st_q.state == PFCV_ST_DELAY && u_link.uv_fault && st_q.timer + 32'h1 == d1_cyc)
    |=> (!st_q.out_en && st_q.state != PFCV_ST_DELAY))
    else $error("Output not shut down at the end of the first delay.");
  a_immediate_off: assert property (
    (st_q.state == PFCV_ST_IDLE && u_link.uv_fault && u_link.code == PFCV_RESP_IMMEDIATE)
    |=> !st_q.out_en)
    else $error("Immediate reaction left the output on.");
  a_infinite_retry: assert property (
    (st_q.state == PFCV_ST_OFF && u_link.retry_limit == `PFCV_RETRY_INFINITE &&
     st_q.timer + 32'h1 == d2_cyc) |=> (st_q.state == PFCV_ST_RESTART && st_q.out_en))
    else $error("Unlimited retries did not restart.");
  a_latch_hold: assert property (
    (st_q.state == PFCV_ST_LATCH) |=> (st_q.state == PFCV_ST_LATCH && !st_q.out_en))
    else $error("Locked-off output came back without reset.");
endmodule : pfcv_resp
`default_nettype wire

// ===== logic/pfcv_top.sv
// Output-voltage limit registers, threshold comparators and undervoltage fault reaction.
`timescale 1ns/1ps
`default_nettype none
`include "pfcv_defines.svh"
module pfcv_top
  import pfcv_pkg::*;
#(
  parameter int unsigned P_CYCLES_PER_MS = `PFCV_CYCLES_PER_MS  // Cycles per ms; shrink for sim.
) (
  input  wire logic        i_clock,          // 20 MHz block clock.
  input  wire logic        i_reset_n,        // Asynchronous active-low reset.
  input  wire logic [7:0]  i_cmd_code,       // Command code of the register access.
  input  wire logic        i_cmd_write,      // One-cycle write strobe.
  input  wire logic        i_cmd_read,       // One-cycle read strobe.
  input  wire logic [15:0] i_cmd_wdata,      // Write data word.
  input  wire logic [2:0]  i_mode_exponent,  // Exponent field of the output-mode setting.
  input  wire logic [15:0] i_vout_meas,      // Output voltage mantissa, same exponent.
  output var  logic [15:0] o_rd_data,        // Read data, held until the next read.
  output var  logic        o_rd_valid,       // One-cycle read answer strobe.
  output var  logic        o_cmd_error,      // One-cycle strobe for an unmapped code.
  output var  logic        o_ov_warning,     // Overvoltage warning level.
  output var  logic        o_uv_warning,     // Undervoltage warning level.
  output var  logic        o_uv_fault,       // Undervoltage fault level.
  output var  logic        o_output_enable,  // Converter output enable.
  output var  logic        o_fault_latched   // Output locked off until reset.
);

  // ---------------------------------------------------------------------------
  // State layout
  // ---------------------------------------------------------------------------

  // The whole register bank and every output flop live in one packed struct.
  typedef struct packed {
    logic [10:0] ov_mant;    // Overvoltage warning mantissa.
    logic [10:0] uvw_mant;   // Undervoltage warning mantissa.
    logic [10:0] uvf_mant;   // Undervoltage fault mantissa.
    logic [7:0]  resp;       // Fault reaction register.
    logic [15:0] rd_data;    // Read answer.
    logic        rd_valid;   // Read answer strobe.
    logic        cmd_error;  // Unmapped access strobe.
    logic        ov;         // Overvoltage warning.
    logic        uvw;        // Undervoltage warning.
    logic        uvf;        // Undervoltage fault.
    logic        out_en;     // Output enable copy.
    logic        latched;    // Lock-off copy.
  } pfcv_top_st_t;

  // Reset image: the output runs, the warnings are clear, thresholds sit at rest.
  localparam pfcv_top_st_t C_RST = '{
    ov_mant:   `PFCV_RST_OV_MANT,
    uvw_mant:  `PFCV_RST_UV_MANT,
    uvf_mant:  `PFCV_RST_UV_MANT,
    resp:      `PFCV_RST_RESP,
    rd_data:   16'h0000,
    rd_valid:  1'b0,
    cmd_error: 1'b0,
    ov:        1'b0,
    uvw:       1'b0,
    uvf:       1'b0,
    out_en:    1'b1,
    latched:   1'b0
  };

  pfcv_top_st_t st_q;         // Registered state.
  pfcv_top_st_t st_d;         // Next state.
  logic [1:0]   rst_sync_q;   // Reset release synchroniser.
  logic         rst_n;        // Synchronised reset, active low.
  logic [4:0]   exp_field;    // Sign-extended exponent for read-back.

  pfcv_resp_if  rif ();       // Link to the reaction sequencer.

  // ---------------------------------------------------------------------------
  // Reset synchroniser
  // ---------------------------------------------------------------------------

  // Assertion is immediate, release takes two edges so no flop sees a runt edge.
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  // Only the second stage is used downstream.
  assign rst_n = rst_sync_q[1];

  // ---------------------------------------------------------------------------
  // Exponent handling
  // ---------------------------------------------------------------------------

  // The exponent is never stored here; it follows the mode setting live.
  // Sign extension keeps negative exponents negative in the five-bit field.
  assign exp_field = pfcv_exp5(i_mode_exponent);

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------

  // Register writes, read answers and the three threshold comparisons.
  always_comb begin
    st_d           = st_q;
    st_d.rd_valid  = 1'b0;
    st_d.cmd_error = 1'b0;

    // Threshold writes keep only the mantissa; exponent bits of the word are dropped.
    if (i_cmd_write) begin
      unique case (i_cmd_code)
        `PFCV_OFS_OV_WARN: begin
          st_d.ov_mant = i_cmd_wdata[`PFCV_MANT_MSB:0];
        end
        `PFCV_OFS_UV_WARN: begin
          st_d.uvw_mant = i_cmd_wdata[`PFCV_MANT_MSB:0];
        end
        `PFCV_OFS_UV_FAULT: begin
          st_d.uvf_mant = i_cmd_wdata[`PFCV_MANT_MSB:0];
        end
        `PFCV_OFS_UV_RESP: begin
          st_d.resp = i_cmd_wdata[7:0];
        end
        default: begin
          // Unknown codes change nothing but are reported.
          st_d.cmd_error = 1'b1;
        end
      endcase
    end

    // A read in the same cycle as a write returns the value from before it.
    if (i_cmd_read) begin
      st_d.rd_valid = 1'b1;
      unique case (i_cmd_code)
        `PFCV_OFS_OV_WARN: begin
          st_d.rd_data = {exp_field, st_q.ov_mant};
        end
        `PFCV_OFS_UV_WARN: begin
          st_d.rd_data = {exp_field, st_q.uvw_mant};
        end
        `PFCV_OFS_UV_FAULT: begin
          st_d.rd_data = {exp_field, st_q.uvf_mant};
        end
        `PFCV_OFS_UV_RESP: begin
          st_d.rd_data = {8'h00, st_q.resp};
        end
        default: begin
          // Unmapped reads answer zero and raise the error strobe.
          st_d.rd_data   = 16'h0000;
          st_d.cmd_error = 1'b1;
        end
      endcase
    end

    // The measurement carries the same exponent as the thresholds, so the
    // mantissas compare directly and an exponent change rescales all three.
    st_d.ov  = i_vout_meas > {5'h00, st_q.ov_mant};
    st_d.uvw = i_vout_meas < {5'h00, st_q.uvw_mant};
    st_d.uvf = i_vout_meas < {5'h00, st_q.uvf_mant};

    // Sequencer results are re-registered so every output leaves a flop.
    st_d.out_en  = rif.out_en;
    st_d.latched = rif.latched;
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------

  // One register for the whole bank; reset loads the constant image.
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= C_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Fault reaction sequencer
  // ---------------------------------------------------------------------------

  // The sequencer reads the registered fault so it never sees a comparator glitch.
  assign rif.uv_fault    = st_q.uvf;
  assign rif.code        = st_q.resp[`PFCV_RESP_CODE_MSB:`PFCV_RESP_CODE_LSB];
  assign rif.retry_limit = st_q.resp[`PFCV_RETRY_MSB:`PFCV_RETRY_LSB];
  assign rif.delay_sel   = st_q.resp[`PFCV_DELAY_MSB:`PFCV_DELAY_LSB];

  // Delays run from 10 ms up to 2604 ms, hence the per-millisecond scale as a parameter.
  pfcv_resp #(
    .P_CYCLES_PER_MS (P_CYCLES_PER_MS)
  ) u_resp (
    .i_clock (i_clock),
    .i_rst_n (rst_n),
    .u_link  (rif.resp)
  );

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------

  // Each output is a field of the state register.
  assign o_rd_data       = st_q.rd_data;
  assign o_rd_valid      = st_q.rd_valid;
  assign o_cmd_error     = st_q.cmd_error;
  assign o_ov_warning    = st_q.ov;
  assign o_uv_warning    = st_q.uvw;
  assign o_uv_fault      = st_q.uvf;
  assign o_output_enable = st_q.out_en;
  assign o_fault_latched = st_q.latched;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!rst_n);

  // Warning follows the comparison one edge later.
  a_ov_compare: assert property (
    (i_vout_meas > {5'h00, st_q.ov_mant}) |=> o_ov_warning)
    else $error("Overvoltage warning missed.");

  // Undervoltage warning tracks its threshold both ways.
  a_uvw_compare: assert property (
    1'b1 |=> (o_uv_warning == ($past(i_vout_meas) < {5'h00, $past(st_q.uvw_mant)})))
    else $error("Undervoltage warning wrong.");

  // Undervoltage fault tracks its threshold both ways.
  a_uvf_compare: assert property (
    1'b1 |=> (o_uv_fault == ($past(i_vout_meas) < {5'h00, $past(st_q.uvf_mant)})))
    else $error("Undervoltage fault wrong.");

  // Read-back exponent is the sign-extended mode exponent.
  a_exp_readback: assert property (
    (i_cmd_read && i_cmd_code == `PFCV_OFS_UV_FAULT) |=>
    (o_rd_valid && o_rd_data[15:11] == {{2{$past(i_mode_exponent[2])}},
                                        $past(i_mode_exponent)}))
    else $error("Exponent read-back wrong.");

  // A written mantissa reads back unchanged when no other write to it intervenes.
  a_mant_readback: assert property (
    (i_cmd_write && i_cmd_code == `PFCV_OFS_OV_WARN) ##1
    !(i_cmd_write && i_cmd_code == `PFCV_OFS_OV_WARN) ##1
    (i_cmd_read && i_cmd_code == `PFCV_OFS_OV_WARN) |=>
    (o_rd_data[10:0] == $past(i_cmd_wdata[10:0], 3)))
    else $error("Mantissa did not read back.");

  // Exponent bits of a write never reach the read-back.
  a_exp_nowrite: assert property (
    (i_cmd_write && i_cmd_code == `PFCV_OFS_UV_WARN) ##2
    (i_cmd_read && i_cmd_code == `PFCV_OFS_UV_WARN) |=>
    (o_rd_data[15:11] == pfcv_exp5($past(i_mode_exponent))))
    else $error("Written exponent leaked into the register.");

  // While faults are ignored the output stays on.
  a_ignore_output: assert property (
    (rif.code == PFCV_RESP_IGNORE && !rif.latched && u_resp.st_q.state == PFCV_ST_IDLE)
    |=> ##1 o_output_enable)
    else $error("Output dropped with reaction code 00.");

endmodule : pfcv_top
`default_nettype wire

// ===== tb/pfcv_host.sv
// Register host model issuing one-cycle command accesses.
`timescale 1ns/1ps
`default_nettype none
module pfcv_host (
  input  wire logic        i_clock,  // Block clock.
  output var  logic [7:0]  o_code,   // Command code.
  output var  logic        o_write,  // Write strobe.
  output var  logic        o_read,   // Read strobe.
  output var  logic [15:0] o_wdata   // Write data.
);
  // ----------------------------------------
  // Access task
  // ----------------------------------------
  // Strobes drop one edge after rising, so each call leaves an idle cycle.
  initial begin
    o_code  = 8'h00;
    o_write = 1'b0;
    o_read  = 1'b0;
    o_wdata = 16'h0000;
  end
  task automatic access(input logic [7:0] c, input logic w, input logic [15:0] d);
    @(posedge i_clock);
    o_code  <= c;
    o_write <= w;
    o_read  <= ~w;
    o_wdata <= d;
    @(posedge i_clock);
    o_write <= 1'b0;
    o_read  <= 1'b0;
    o_wdata <= ~d;  // Stale data is inverted so it never looks valid.
  endtask
endmodule // pfcv_host
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for the output-voltage limits block.
`timescale 1ns/1ps
`default_nettype none
`include "pfcv_defines.svh"
module testbench;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        clock = 1'b0;  // Block clock.
  logic        reset_n;       // Active-low reset.
  logic [7:0]  code;          // Command code.
  logic        wr, rd;        // Strobes.
  logic [15:0] wdata, meas;   // Write data and measurement.
  logic [15:0] rdata;         // Read answer.
  logic [2:0]  mexp;          // Mode exponent.
  logic        rvalid, cerr, ovw, uvw, uvf, oen, flat;  // Outputs.
  logic [16:0] expq[$];       // Expected {error, data} per read.
  int          fails = 0, compares = 0, cycles = 0, seed = 20, i;
  logic [15:0] d;             // Random word.
  logic [2:0]  e;             // Random exponent.
  logic [15:0] lv_meas [4] = '{16'h0301, 16'h0300, 16'h024F, 16'h00FF};
  logic [2:0]  lv_exp [4] = '{3'h4, 3'h0, 3'h2, 3'h3};  // {ov, uv warn, uv fault}.
  always #25 clock = ~clock;  // 20 MHz.
  pfcv_host pfcv_host_inst (.i_clock(clock), .o_code(code), .o_write(wr), .o_read(rd),
    .o_wdata(wdata));
  pfcv_top #(.P_CYCLES_PER_MS(2)) pfcv_top_inst (.i_clock(clock), .i_reset_n(reset_n),
    .i_cmd_code(code), .i_cmd_write(wr), .i_cmd_read(rd), .i_cmd_wdata(wdata),
    .i_mode_exponent(mexp), .i_vout_meas(meas), .o_rd_data(rdata), .o_rd_valid(rvalid),
    .o_cmd_error(cerr), .o_ov_warning(ovw), .o_uv_warning(uvw), .o_uv_fault(uvf),
    .o_output_enable(oen), .o_fault_latched(flat));
  // ----------------------------------------
  // Compare and closing tasks
  // ----------------------------------------
  task automatic chk(input string n, input logic [16:0] x, input logic [16:0] g);
    compares++;
    if (g !== x) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic complete_run();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // A hang counts as a mismatch; the longest sequence needs well under this.
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      complete_run();
    end
  end
  // Answers are checked at the falling edge, away from the launching edge.
  always @(negedge clock) begin
    if (rvalid === 1'b1 || cerr === 1'b1) begin
      if (expq.size() == 0) chk("unexpected answer", 17'h0, {cerr, rdata});
      else chk("read answer", expq.pop_front(), {cerr, rdata});
    end
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic rd_exp(input logic [7:0] c, input logic [16:0] x);
    expq.push_back(x);
    pfcv_host_inst.access(c, 1'b0, 16'h0000);
  endtask
  task automatic lvl(input int n);  // Waits n cycles, then looks at the outputs.
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic do_reset();
    reset_n <= 1'b0;
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    repeat (3) @(posedge clock);
  endtask
  task automatic limits();  // OV 0x300, UV warn 0x250, UV fault 0x100.
    pfcv_host_inst.access(`PFCV_OFS_OV_WARN, 1'b1, 16'h0300);
    pfcv_host_inst.access(`PFCV_OFS_UV_WARN, 1'b1, 16'h0250);
    pfcv_host_inst.access(`PFCV_OFS_UV_FAULT, 1'b1, 16'h0100);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    reset_n = 1'b0;
    mexp = 3'h0;
    meas = 16'h0200;
    do_reset();
    rd_exp(`PFCV_OFS_OV_WARN, 17'h007FF);
    rd_exp(`PFCV_OFS_UV_WARN, 17'h00000);
    rd_exp(`PFCV_OFS_UV_FAULT, 17'h00000);
    rd_exp(`PFCV_OFS_UV_RESP, 17'h00000);
    rd_exp(8'h45, 17'h10000);  // Unmapped code answers zero with an error.
    for (i = 0; i < 6; i++) begin
      d = $random(seed);
      e = $random(seed);
      mexp <= e;
      pfcv_host_inst.access(8'(`PFCV_OFS_OV_WARN + i % 3), 1'b1, d);
      rd_exp(8'(`PFCV_OFS_OV_WARN + i % 3), {1'b0, {2{e[2]}}, e, d[10:0]});
    end
    mexp <= 3'h0;
    limits();
    for (i = 0; i < 4; i++) begin
      meas <= lv_meas[i];
      lvl(3);
      chk("warnings", {14'h0, lv_exp[i]}, {14'h0, ovw, uvw, uvf});
    end
    lvl(30);
    chk("enable code 00", 17'h1, {16'h0, oen});
    pfcv_host_inst.access(`PFCV_OFS_UV_RESP, 1'b1, 16'h0040);
    lvl(10);
    chk("enable in delay", 17'h1, {16'h0, oen});
    lvl(30);
    chk("lock code 01", 17'h2, {15'h0, flat, oen});
    meas <= 16'h0200;
    lvl(10);
    chk("lock held", 17'h2, {15'h0, flat, oen});
    do_reset();
    limits();
    pfcv_host_inst.access(`PFCV_OFS_UV_RESP, 1'b1, 16'h0088);
    meas <= 16'h00FF;
    lvl(6);
    chk("immediate off", 17'h0, {15'h0, flat, oen});
    lvl(490);
    chk("off interval", 17'h0, {15'h0, flat, oen});
    lvl(22);
    chk("restart", 17'h1, {15'h0, flat, oen});
    lvl(60);
    chk("retries spent", 17'h2, {15'h0, flat, oen});
    // Spare code acts at once; unlimited retries must never lock the output off.
    do_reset();
    limits();
    pfcv_host_inst.access(`PFCV_OFS_UV_RESP, 1'b1, 16'h00F8);
    lvl(6);
    chk("spare code off", 17'h0, {15'h0, flat, oen});
    lvl(1034);
    chk("endless retry", 17'h1, {15'h0, flat, oen});
    lvl(2);
    complete_run();
  end
endmodule // testbench
`default_nettype wire
